// [tfcp_exc_model.sv]
// partner model: exception-side strobe toward the pointer pair
`timescale 1ns/1ps
module tfcp_exc_model
	import tfcp_pkg::*;
(
	input  wire logic        fire,
	input  wire logic [31:0] va,
	output tfcp_exc_s        exc
);
	// =====================================================================
	// one-cycle strobe per fault; address inverted while idle, never stale
	assign exc = '{tlb_upd: fire, addr_err: 1'b0, fault_va: fire ? va : ~va};
endmodule : tfcp_exc_model

// [tfcp_pkg.sv]
// package: constants and carriers for the fault-context pointer register pair
package tfcp_pkg;

	// =====================================================================
	// register layout
	localparam int unsigned   TFCP_W              = 32;
	localparam logic [31:0]   TFCP_MASK_RESET     = 32'h007f_fff0;
	localparam logic [31:0]   TFCP_MASK_ALT_4B    = 32'h007f_fff8;
	localparam logic [31:0]   TFCP_FIXED_FIELD    = 32'h007f_fff0;
	localparam logic [31:0]   TFCP_FIXED_BASE     = 32'hff80_0000;
	localparam logic [31:0]   TFCP_FIXED_LOW      = 32'h0000_000f;
	localparam logic [31:0]   TFCP_ZERO           = 32'h0000_0000;
	localparam logic [31:0]   TFCP_ONES           = 32'hffff_ffff;
	localparam int unsigned   TFCP_FIXED_LSB      = 4;
	localparam int unsigned   TFCP_FIXED_VA_LSB   = 13;
	localparam int unsigned   TFCP_VA_LSB_4K      = 13;
	localparam int unsigned   TFCP_VA_LSB_1K      = 11;

	// =====================================================================
	// register select codes
	typedef enum logic [0:0] {
		TFCP_SEL_POINTER = 1'b0,
		TFCP_SEL_MASK    = 1'b1
	} tfcp_sel_e;

	// software access request
	typedef struct packed {
		logic             wr_en;
		tfcp_sel_e        sel;
		logic [31:0]      wdata;
	} tfcp_sw_req_s;

	// exception-side update strobe
	typedef struct packed {
		logic             tlb_upd;
		logic             addr_err;
		logic [31:0]      fault_va;
	} tfcp_exc_s;

endpackage : tfcp_pkg

// [tfcp_pointer.sv]
// module: page-table pointer and index-mask registers with fault merge
`timescale 1ns/1ps

// Functional notes
// - fixed layout: tlb fault loads va 31..13 into pointer 22:4, read-only
// - fixed layout: bits 31:23 are software base, untouched by exceptions
// - fixed layout: low four bits read zero, reset zero, software writes zero
// - after address error the faulting-page field is undefined, may change
// - configurable layout: fault writes top va bits into mask-selected run
// - configurable layout: bits above and below run keep value on faults
// - small mode: bits below lowest mask one always read zero
// - low bits read-only zero, or read-write only with configurable feature
// - pointer undefined after mask change until software rewrites it
// - mask is 32-bit read-write contiguous ones, reset 0x007ffff0
// - all-zero mask makes whole pointer software owned, no fault updates
// - unsupported mask settings read back different, supported ones exactly; only sub-floor bits are dropped, non-contiguous masks read back as written
// - every mask implementation can reproduce fixed layout 22:4 from va 31..13
// - lowest writable mask bit limited to smallest page-pair bit
// - mask exists only with a presence flag, else fixed layout
module tfcp_pointer
	import tfcp_pkg::*;
#(
	parameter bit          CFG_PRESENT   = 1'b1,
	parameter bit          SMALL_PRESENT = 1'b0,
	parameter bit          LOW_BITS_RW   = 1'b0,
	parameter int unsigned MIN_VA_LSB    = TFCP_VA_LSB_4K
) (
	input  wire logic          mclk,
	input  wire logic          arst_n,
	input  wire tfcp_sw_req_s  sw_req,
	input  wire tfcp_exc_s     exc,
	output logic [31:0]        pointer_rdata,
	output logic [31:0]        mask_rdata,
	output logic               configurable_pointer_present,
	output logic               small_mode_present
);

	// =====================================================================
	// helper functions

	// lowest mask bit position allowed to be one; va bit MIN_VA_LSB sits at
	// pointer bit (MIN_VA_LSB - 9) once the run tops out at bit 22
	localparam int unsigned MASK_FLOOR = MIN_VA_LSB - (TFCP_FIXED_VA_LSB - TFCP_FIXED_LSB);

	// bits below the lowest set bit of a mask; an empty mask has none
	// bits below the lowest set bit of a mask
	function automatic logic [31:0] below_run(input logic [31:0] m);
		logic [31:0] lsb;
		lsb = m & (~m + 32'h0000_0001);
		return (m == TFCP_ZERO) ? TFCP_ZERO : (lsb - 32'h0000_0001);
	endfunction : below_run

	// align top va bits onto the mask-selected run of pointer bits
	// va bit 31 lands on the highest mask one, then downward one bit per
	// mask one; a non-contiguous mask still fills its ones in order, which
	// is as good as any answer for a setting that software must not use
	function automatic logic [31:0] place_va(input logic [31:0] m, input logic [31:0] va);
		logic [31:0] res;
		int          hi;
		int          k;
		res = TFCP_ZERO;
		hi  = -1;
		for (int i = 0; i < TFCP_W; i++) begin
			if (m[i]) begin
				hi = i;
			end
		end
		k = TFCP_W - 1;
		for (int i = TFCP_W - 1; i >= 0; i--) begin
			if (m[i] && i <= hi) begin
				res[i] = va[k];
				k      = k - 1;
			end
		end
		return res;
	endfunction : place_va

	// mask writes are restricted: bits below the floor are hard-wired zero
	// a write that sets them reads back different, which is how software
	// probes the smallest supported page
	function automatic logic [31:0] legal_mask(input logic [31:0] w);
		logic [31:0] floor_m;
		floor_m = TFCP_ONES << MASK_FLOOR;
		return w & floor_m;
	endfunction : legal_mask

	// decode of a software write aimed at one register
	function automatic logic sw_hit(input tfcp_sw_req_s req, input tfcp_sel_e s);
		return req.wr_en && (req.sel == s);
	endfunction : sw_hit

	// =====================================================================
	// effective layout
	logic          has_mask;
	logic [31:0]   eff_mask;
	logic [31:0]   low_zero;
	logic [31:0]   mask_q;
	logic [31:0]   mask_d;
	logic [31:0]   ptr_q;
	logic [31:0]   ptr_d;
	logic [31:0]   ptr_view;
	logic          sw_ptr_wr;
	logic          sw_mask_wr;

	assign has_mask = CFG_PRESENT || SMALL_PRESENT;

	// =====================================================================
	// software write decode
	assign sw_ptr_wr  = sw_hit(sw_req, TFCP_SEL_POINTER);
	assign sw_mask_wr = sw_hit(sw_req, TFCP_SEL_MASK);

	// fixed layout when no mask register exists
	// small mode, or read-only low bits, force bits below the run to zero
	always_comb begin
		if (has_mask) begin
			eff_mask = mask_q;
			low_zero = (SMALL_PRESENT || !LOW_BITS_RW) ? below_run(mask_q) : TFCP_ZERO;
		end else begin
			eff_mask = TFCP_FIXED_FIELD;
			low_zero = TFCP_FIXED_LOW;
		end
	end

	// =====================================================================
	// mask register
	always_comb begin
		mask_d = mask_q;
		// writes without a mask register are dropped
		if (has_mask && sw_mask_wr) begin
			mask_d = legal_mask(sw_req.wdata);
		end
	end

	// the mask register resets to TFCP_MASK_RESET
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= TFCP_MASK_RESET;
		end else begin
			mask_q <= mask_d;
		end
	end

	// =====================================================================
	// pointer register: software owns unmasked bits, fault owns masked ones
	always_comb begin
		ptr_d = ptr_q;
		// software write first, then the fault strobe on top
		if (sw_ptr_wr) begin
			ptr_d = (ptr_q & eff_mask) | (sw_req.wdata & ~eff_mask);
		end
		if (exc.tlb_upd) begin
			ptr_d = (ptr_d & ~eff_mask) | place_va(eff_mask, exc.fault_va);
		end
		// clear bits that read as zero
		ptr_d = ptr_d & ~low_zero;
	end

	// pointer content is free after reset; clearing it keeps the read-only
	// low bits at zero and gives every check a known start
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_q <= TFCP_ZERO;
		end else begin
			// address errors leave the faulting field as it stands, which is allowed
			ptr_q <= ptr_d;
		end
	end

	assign ptr_view = ptr_q & ~low_zero;

	// =====================================================================
	// registered pointer read view
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pointer_rdata <= TFCP_ZERO;
		end else begin
			pointer_rdata <= ptr_view;
		end
	end

	// registered mask read view, zero without a mask register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mask_rdata <= TFCP_ZERO;
		end else begin
			mask_rdata <= has_mask ? mask_q : TFCP_ZERO;
		end
	end

	// configurable-pointer presence flag
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			configurable_pointer_present <= 1'b0;
		end else begin
			configurable_pointer_present <= CFG_PRESENT;
		end
	end

	// small-mode presence flag
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			small_mode_present <= 1'b0;
		end else begin
			small_mode_present <= SMALL_PRESENT;
		end
	end

	// =====================================================================
	// checks: named steps
	// a fault strobe with no mask write racing it in the same cycle
	sequence s_fault_upd;
		exc.tlb_upd && !sw_mask_wr;
	endsequence

	// software write into the pointer with no fault in the same cycle
	sequence s_sw_ptr_only;
		sw_ptr_wr && !exc.tlb_upd;
	endsequence

	// no fault, no software write, and a mask that has settled
	sequence s_quiet;
		!exc.tlb_upd && !sw_req.wr_en && $stable(mask_q);
	endsequence

	// software write into an existing mask register
	sequence s_mask_wr;
		has_mask && sw_mask_wr;
	endsequence

	// =====================================================================
	// checks: reset and presence
	// mask leaves reset at its documented value
	AST_MASK_RESET: assert property (@(posedge mclk) $rose(arst_n) |-> mask_q == TFCP_MASK_RESET)
		else $error("mask not at reset value");

	// out of reset the mask reproduces the fixed layout
	AST_FIXED_AT_RESET: assert property (@(posedge mclk) $rose(arst_n) |-> eff_mask == TFCP_FIXED_FIELD)
		else $error("reset layout not fixed");

	// presence flags follow the build options once out of reset
	AST_CFG_FLAG: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> configurable_pointer_present == CFG_PRESENT)
		else $error("configurable flag wrong");

	// small-mode flag likewise
	AST_SM_FLAG: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> small_mode_present == SMALL_PRESENT)
		else $error("small mode flag wrong");

	// =====================================================================
	// checks: fault merge
	// faulting field takes the top address bits
	AST_FAULT_MERGE: assert property (@(posedge mclk) disable iff (!arst_n)
		s_fault_upd |=> ((ptr_q & eff_mask) == place_va(eff_mask, $past(exc.fault_va))))
		else $error("faulting field not loaded");

	// fixed field worked out by shifts, independent of the placing function
	AST_FAULT_FIXED: assert property (@(posedge mclk) disable iff (!arst_n)
		(exc.tlb_upd && !sw_mask_wr && eff_mask == TFCP_FIXED_FIELD)
		|=> ((ptr_q & TFCP_FIXED_FIELD) == (($past(exc.fault_va) >> TFCP_FIXED_VA_LSB) << TFCP_FIXED_LSB)))
		else $error("fixed field not loaded");

	// fault wins the masked bits over a software write in the same cycle
	AST_FAULT_BEATS_SW: assert property (@(posedge mclk) disable iff (!arst_n)
		(exc.tlb_upd && sw_ptr_wr) |=> ((ptr_q & eff_mask) == place_va(eff_mask, $past(exc.fault_va))))
		else $error("software beat the fault");

	// software bits survive a fault
	AST_FAULT_KEEPS_BASE: assert property (@(posedge mclk) disable iff (!arst_n)
		(exc.tlb_upd && !sw_req.wr_en) |=> ((ptr_q & ~eff_mask) == ($past(ptr_q) & ~eff_mask)))
		else $error("fault altered software bits");

	// an empty mask shields the whole pointer from faults
	AST_ZERO_MASK: assert property (@(posedge mclk) disable iff (!arst_n)
		(eff_mask == TFCP_ZERO && exc.tlb_upd && !sw_req.wr_en) |=> ptr_q == $past(ptr_q))
		else $error("zero mask fault changed pointer");

	// idle cycles leave the pointer untouched
	AST_PTR_QUIET: assert property (@(posedge mclk) disable iff (!arst_n)
		s_quiet |=> ptr_q == $past(ptr_q))
		else $error("pointer changed while idle");

	// =====================================================================
	// checks: software side
	// software cannot reach the faulting field
	AST_SW_NO_FIELD: assert property (@(posedge mclk) disable iff (!arst_n)
		s_sw_ptr_only |=> ((ptr_q & eff_mask) == ($past(ptr_q) & $past(eff_mask))))
		else $error("software wrote faulting field");

	// software base lands as written
	AST_SW_BASE: assert property (@(posedge mclk) disable iff (!arst_n)
		sw_ptr_wr |=> ((ptr_q & ~eff_mask & ~low_zero) == ($past(sw_req.wdata) & ~eff_mask & ~low_zero)))
		else $error("base field write lost");

	// with no mask every pointer bit takes the written word as is
	AST_ZERO_MASK_SW: assert property (@(posedge mclk) disable iff (!arst_n)
		(eff_mask == TFCP_ZERO && sw_ptr_wr && !exc.tlb_upd) |=> ptr_q == $past(sw_req.wdata))
		else $error("zero mask write not whole");

	// read view never shows read-only bits below the run
	AST_LOW_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> ((pointer_rdata & $past(low_zero)) == TFCP_ZERO))
		else $error("low bits not zero");

	// read-only low bits stay clear in the register itself
	AST_LOW_HELD: assert property (@(posedge mclk) disable iff (!arst_n)
		!sw_mask_wr |=> ((ptr_q & low_zero) == TFCP_ZERO))
		else $error("low bits held ones");

	// read view trails the register by one edge
	AST_PTR_RDATA: assert property (@(posedge mclk) disable iff (!arst_n)
		1'b1 |=> pointer_rdata == $past(ptr_view))
		else $error("pointer read view stale");

	// =====================================================================
	// checks: mask register
	// supported settings read back exactly
	AST_MASK_READBACK: assert property (@(posedge mclk) disable iff (!arst_n)
		s_mask_wr |=> mask_q == legal_mask($past(sw_req.wdata)))
		else $error("mask readback wrong");

	// an all-zero write is a supported setting and reads back as zero
	AST_MASK_ZERO_WR: assert property (@(posedge mclk) disable iff (!arst_n)
		(has_mask && sw_mask_wr && sw_req.wdata == TFCP_ZERO) |=> mask_q == TFCP_ZERO)
		else $error("zero mask not accepted");

	// mask only moves on a write
	AST_MASK_QUIET: assert property (@(posedge mclk) disable iff (!arst_n)
		!sw_mask_wr |=> mask_q == $past(mask_q))
		else $error("mask changed without a write");

	// mask read view trails the register by one edge
	AST_MASK_RDATA: assert property (@(posedge mclk) disable iff (!arst_n)
		has_mask |=> mask_rdata == $past(mask_q))
		else $error("mask read view stale");

	// no mask one below the smallest page-pair bit
	AST_MASK_FLOOR: assert property (@(posedge mclk) disable iff (!arst_n)
		(mask_q & ~(TFCP_ONES << MASK_FLOOR)) == TFCP_ZERO)
		else $error("mask bit below floor");

endmodule : tfcp_pointer

// [tfcp_pointer_bench.sv]
// testbench: scenarios for the fault-context pointer pair
`timescale 1ns/1ps
module tfcp_pointer_bench
	import tfcp_pkg::*;
;
	logic         mclk       = 1'b0;
	logic         arst_n     = 1'b0;
	tfcp_sw_req_s sw_req     = '0;
	logic         fire       = 1'b0;
	logic [31:0]  va         = 32'h0000_0000;
	tfcp_exc_s    exc;
	logic [31:0]  ptr_rd;
	logic [31:0]  mask_rd;
	logic         cfg_p;
	logic         sm_p;
	int           n_fail     = 0;
	int           n_compared = 0;

	// =====================================================================
	// clock, partner and device
	always #2.5 mclk = ~mclk;
	tfcp_exc_model exc_u (.fire(fire), .va(va), .exc(exc));
	tfcp_pointer dut_u (.mclk(mclk), .arst_n(arst_n), .sw_req(sw_req), .exc(exc), .pointer_rdata(ptr_rd),
		.mask_rdata(mask_rd), .configurable_pointer_present(cfg_p), .small_mode_present(sm_p));

	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one write pulse, returns once read view shows it
	task wr(input tfcp_sel_e s, input logic [31:0] d);
		sw_req = '{wr_en: 1'b1, sel: s, wdata: d};
		@(negedge mclk);
		sw_req.wr_en = 1'b0;
		@(negedge mclk);
	endtask : wr

	// one fault strobe through the partner
	task flt(input logic [31:0] v);
		fire = 1'b1;
		va   = v;
		@(negedge mclk);
		fire = 1'b0;
		@(negedge mclk);
	endtask : flt

	// fixed layout expectation: base kept, field from top address bits
	function automatic logic [31:0] fixed_exp(input logic [31:0] v);
		return TFCP_FIXED_BASE | ((v >> TFCP_FIXED_VA_LSB) << TFCP_FIXED_LSB);
	endfunction : fixed_exp

	task t_reset;
		chk(mask_rd, TFCP_MASK_RESET);
		chk({30'h0, cfg_p, sm_p}, 32'h0000_0002);
	endtask : t_reset

	task t_fixed;
		flt(32'haaaa_aaaa);
		wr(TFCP_SEL_POINTER, TFCP_ONES);
		chk(ptr_rd, fixed_exp(32'haaaa_aaaa));
		flt(32'h5555_5555);
		chk(ptr_rd, fixed_exp(32'h5555_5555));
	endtask : t_fixed

	task t_mask;
		wr(TFCP_SEL_MASK, TFCP_ONES);
		chk(mask_rd, 32'hffff_fff0);
		wr(TFCP_SEL_MASK, TFCP_MASK_ALT_4B);
		chk(mask_rd, TFCP_MASK_RESET);
		wr(TFCP_SEL_MASK, 32'h00ff_f000);
		chk(mask_rd, 32'h00ff_f000);
		wr(TFCP_SEL_POINTER, TFCP_ONES);
		flt(32'h8000_0001);
		chk(ptr_rd, 32'hff80_0000);
	endtask : t_mask

	task t_zero;
		wr(TFCP_SEL_MASK, TFCP_ZERO);
		wr(TFCP_SEL_POINTER, TFCP_ONES);
		flt(32'h1234_5678);
		chk(ptr_rd, TFCP_ONES);
		wr(TFCP_SEL_MASK, TFCP_MASK_RESET);
		chk(mask_rd, TFCP_MASK_RESET);
	endtask : t_zero

	// verdict and end of run
	task final_report;
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	// main sequence
	initial begin
		repeat (2) @(negedge mclk);
		arst_n = 1'b1;
		@(negedge mclk);
		t_reset;
		t_fixed;
		t_mask;
		t_zero;
		final_report;
	end

	// watchdog, far beyond the few dozen cycles the run needs
	initial begin
		#(400 * 5);
		n_fail++;
		final_report;
	end
endmodule : tfcp_pointer_bench
